// >>> design/mpm_top.sv
// phase count detection and operating mode selection
// assumes analog comparators outside supply the trip, ramp,
// zero-cross, probe and per-phase pwm end levels
// Overview of operation
// - at enable sink probe current on phases 2 and 3; high pin disables phase
// - finish phase detection within three internal oscillator cycles
// - remove the probe current sink once detection is done
// - tied-high phases stay high impedance, as does phase 3 when phase 2 is tied; others act as normal pwm outputs
// - each phase controlled independently; near full duty and overlap allowed
// - power state high and deeper sleep low run all phases interleaved pwm
// - power state low or deeper sleep high, no transient or limit: phase 1 only
// - single phase from power state uses ripple mode, ccm, no master clock
// - single phase from deeper sleep uses ripple mode gated by zero cross
// - transient window or current limit forces all phases into pwm ccm
// - transient window starts at each code change, lasts the masking time
// - multiphase switching is timed by the master clock
// - per-phase rate is master clock divided by phases in use
// - ripple mode sets phase 1 high when ripple threshold is reached
// - ripple mode ramp rises while high; output drops when ramp meets node
// - ripple pulse rate falls with load in dcm, steady in ccm
// - multiphase disable driven low in single phase operation or shutdown
// - zero cross output driven low when inductor current crosses zero in dcm ripple mode
`timescale 1ns/1ps
`default_nettype none
`include "mpm_consts.svh"
module mpm_top #(
   parameter int MASK_CYCLES = `MPM_MASK_CYC
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire mpm_pkg::mpm_wb_req_t wb_req_i,
   output mpm_pkg::mpm_wb_rsp_t wb_rsp_o,
   input wire logic power_state_in_i,
   input wire logic deeper_sleep_in_i,
   input wire logic current_limit_i,
   input wire logic [6:0] voltage_id_code_i,
   input wire logic ripple_trip_i,
   input wire logic ramp_reach_i,
   input wire logic zero_cross_det_i,
   input wire logic [2:0] pwm_end_i,
   input wire logic phase2_probe_high_i,
   input wire logic phase3_probe_high_i,
   output mpm_pkg::mpm_pin_t phase1_pulse_out_o,
   output mpm_pkg::mpm_pin_t phase2_pulse_out_o,
   output mpm_pkg::mpm_pin_t phase3_pulse_out_o,
   output logic [1:0] probe_sink_o,
   output mpm_pkg::mpm_pin_t multiphase_disable_out_o,
   output mpm_pkg::mpm_pin_t zero_cross_out_o
);
   import mpm_pkg::*;

   localparam logic [15:0] MASK_LOAD = 16'(MASK_CYCLES);

   // ************************************************************
   // input synchronisers
   // ************************************************************
   mpm_sys_t raw;
   mpm_sys_t s;

   assign raw.power_state_in = power_state_in_i;
   assign raw.dslp = deeper_sleep_in_i;
   assign raw.ilim = current_limit_i;
   assign raw.trip = ripple_trip_i;
   assign raw.ramp = ramp_reach_i;
   assign raw.zc = zero_cross_det_i;
   assign raw.p2hi = phase2_probe_high_i;
   assign raw.p3hi = phase3_probe_high_i;
   assign raw.pwm_end = pwm_end_i;
   assign raw.voltage_id_code = voltage_id_code_i;

   // mode changes land only on clock edges
   mpm_sync u_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .d_i(raw),
      .q_o(s)
   );

   // ************************************************************
   // state
   // ************************************************************
   mpm_core_st_t st_r;
   mpm_core_st_t st_nxt;
   logic running;
   logic trans;
   logic full;
   mpm_mode_t mode;
   logic [2:0] act_mask;
   logic [1:0] nph_eff;
   logic [2:0] pg_pulse;
   logic [2:0] out_nxt;
   logic req;
   logic [31:0] stat_w;

   assign running = (st_r.fsm == MPM_ST_RUN);
   assign trans = (st_r.mask_cnt != 16'h0000);
   // transient or limit overrides the system signals
   assign full = trans || s.ilim || (s.power_state_in && !s.dslp);

   always_comb begin
      if (!running) begin
         mode = MPM_MD_OFF;
      end else if (full) begin
         mode = MPM_MD_PWM;
      end else if (s.dslp) begin
         mode = MPM_MD_RPM_DCM;
      end else begin
         mode = MPM_MD_RPM_CCM;
      end
   end

   // only phase 1 is kept in light load
   assign act_mask = (mode == MPM_MD_PWM) ? st_r.en_mask : 3'h0;
   assign nph_eff = full ? st_r.nph : 2'h1;

   // ************************************************************
   // interleaved pwm
   // ************************************************************
   mpm_phase_gen u_pg (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .tick_i(st_r.tick),
      .nph_i(nph_eff),
      .en_i(act_mask),
      .end_i(s.pwm_end),
      .pulse_o(pg_pulse)
   );

   // ripple mode uses its own latch, never the master tick
   assign out_nxt = (mode == MPM_MD_PWM) ? pg_pulse : {2'h0, st_r.rpm_p1};

   assign req = wb_req_i.cyc && wb_req_i.stb;
   assign stat_w = {23'h000000, st_r.en_mask, (st_r.fsm == MPM_ST_PROBE),
      trans, mode, st_r.nph};

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;

      // master clock divider
      if (st_r.fsm == MPM_ST_OFF || st_r.div_cnt == 16'h0000) begin
         st_nxt.div_cnt = st_r.div;
         st_nxt.tick = (st_r.fsm != MPM_ST_OFF);
      end else begin
         st_nxt.div_cnt = st_r.div_cnt - 16'h0001;
      end

      unique case (st_r.fsm)
         MPM_ST_OFF: begin
            st_nxt.pcnt = 2'h0;
            if (st_r.enable) begin
               st_nxt.fsm = MPM_ST_PROBE;
            end
         end
         MPM_ST_PROBE: begin
            if (st_r.tick) begin
               st_nxt.pcnt = st_r.pcnt + 2'h1;
            end
            // decision taken at the third master clock
            if (st_r.tick && st_r.pcnt == `MPM_PROBE_TICKS - 2'h1) begin
               st_nxt.fsm = MPM_ST_RUN;
               // phase 2 tied means one phase whatever phase 3 does
               st_nxt.en_mask = {!s.p3hi && !s.p2hi, !s.p2hi, 1'b1};
               st_nxt.nph = s.p2hi ? 2'h1 : (s.p3hi ? 2'h2 : 2'h3);
            end
            if (!st_r.enable) begin
               st_nxt.fsm = MPM_ST_OFF;
            end
         end
         MPM_ST_RUN: begin
            if (!st_r.enable) begin
               st_nxt.fsm = MPM_ST_OFF;
            end
         end
         default: begin
            st_nxt.fsm = MPM_ST_OFF;
         end
      endcase

      // sink only while probing
      st_nxt.sink = (st_nxt.fsm == MPM_ST_PROBE);

      // transient window: any code change, deeper sleep entry or exit
      st_nxt.vid_q = s.voltage_id_code;
      st_nxt.dslp_q = s.dslp;
      if (running && (s.voltage_id_code != st_r.vid_q || s.dslp != st_r.dslp_q)) begin
         st_nxt.mask_cnt = MASK_LOAD;
      end else if (trans) begin
         st_nxt.mask_cnt = st_r.mask_cnt - 16'h0001;
      end

      // ripple mode phase 1 latch
      if (mode == MPM_MD_RPM_CCM || mode == MPM_MD_RPM_DCM) begin
         if (!st_r.rpm_p1 && s.trip) begin
            st_nxt.rpm_p1 = 1'b1;
         end else if (st_r.rpm_p1 && s.ramp) begin
            st_nxt.rpm_p1 = 1'b0;
         end
      end else begin
         st_nxt.rpm_p1 = 1'b0;
      end

      // pins: tied-high phases, and phase 3 when phase 2 is tied, float; others drive while running
      st_nxt.out = out_nxt;
      st_nxt.oe = running ? st_r.en_mask : 3'h0;
      st_nxt.md_oe = !running || !full;
      // zero cross gates the low side in dcm, so the rate follows load
      st_nxt.zc_oe = (mode == MPM_MD_RPM_DCM) && s.zc;

      // wishbone slave, one wait state
      st_nxt.ack = req && !st_r.ack;
      if (req && !st_r.ack) begin
         unique case (wb_req_i.adr)
            `MPM_ADR_CTRL: st_nxt.rdat = {31'h00000000, st_r.enable};
            `MPM_ADR_STAT: st_nxt.rdat = stat_w;
            `MPM_ADR_DIV: st_nxt.rdat = {16'h0000, st_r.div};
            default: st_nxt.rdat = 32'h00000000;
         endcase
      end
      if (req && st_r.ack && wb_req_i.we) begin
         if (wb_req_i.adr == `MPM_ADR_CTRL && wb_req_i.sel[0]) begin
            st_nxt.enable = wb_req_i.dat[`MPM_CTRL_EN];
         end
         if (wb_req_i.adr == `MPM_ADR_DIV) begin
            if (wb_req_i.sel[0]) begin
               st_nxt.div[7:0] = wb_req_i.dat[7:0];
            end
            if (wb_req_i.sel[1]) begin
               st_nxt.div[15:8] = wb_req_i.dat[15:8];
            end
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_r <= '0;
         st_r.md_oe <= 1'b1;
         st_r.div <= `MPM_DIV_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign wb_rsp_o.ack = st_r.ack;
   assign wb_rsp_o.dat = st_r.rdat;
   assign phase1_pulse_out_o.out = st_r.out[0];
   assign phase1_pulse_out_o.oe = st_r.oe[0];
   assign phase2_pulse_out_o.out = st_r.out[1];
   assign phase2_pulse_out_o.oe = st_r.oe[1];
   assign phase3_pulse_out_o.out = st_r.out[2];
   assign phase3_pulse_out_o.oe = st_r.oe[2];
   assign probe_sink_o = {st_r.sink, st_r.sink};
   // open-drain style: drive only low
   assign multiphase_disable_out_o.out = 1'b0;
   assign multiphase_disable_out_o.oe = st_r.md_oe;
   assign zero_cross_out_o.out = 1'b0;
   assign zero_cross_out_o.oe = st_r.zc_oe;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence seq_trip_in_rpm;
      (mode == MPM_MD_RPM_CCM || mode == MPM_MD_RPM_DCM) && !st_r.rpm_p1 && s.trip;
   endsequence

   sequence seq_p1_driven;
      st_r.rpm_p1 ##1 phase1_pulse_out_o.out;
   endsequence

   sequence seq_rpm_level;
      running && (mode == MPM_MD_RPM_CCM || mode == MPM_MD_RPM_DCM);
   endsequence

   sequence seq_window_hold;
      trans && !(running && (s.voltage_id_code != st_r.vid_q || s.dslp != st_r.dslp_q));
   endsequence

   AST_NO_SINK_RUN: assert property (running |-> probe_sink_o == 2'h0)
      else $error("probe sink active while running");
   AST_PROBE_END: assert property ((st_r.fsm == MPM_ST_PROBE && st_r.enable && st_r.tick
      && st_r.pcnt == 2'h2) |=> running ##1 probe_sink_o == 2'h0)
      else $error("probe not finished at third tick");
   AST_SINK_PROBE: assert property ($rose(st_r.fsm == MPM_ST_PROBE) |=> probe_sink_o == 2'h3)
      else $error("probe sink missing");
   AST_HIZ_P3: assert property ((running && !st_r.en_mask[2]) [*2] |-> !phase3_pulse_out_o.oe)
      else $error("disabled phase 3 driven");
   AST_SINGLE: assert property ((running && !full) |=> !st_r.out[1] && !st_r.out[2])
      else $error("phase 2 or 3 pulsing in single phase");
   AST_ILIM_FULL: assert property ((running && s.ilim) |-> mode == MPM_MD_PWM)
      else $error("current limit not forcing pwm");
   AST_MASK_LOAD: assert property ((running && s.voltage_id_code != st_r.vid_q) |=> st_r.mask_cnt == MASK_LOAD)
      else $error("transient window not started");
   AST_RPM_SET: assert property (seq_trip_in_rpm |=> seq_p1_driven)
      else $error("ripple trip did not raise phase 1");
   AST_RPM_CLR: assert property ((st_r.rpm_p1 && s.ramp) |=> !st_r.rpm_p1)
      else $error("ramp did not end phase 1 pulse");
   AST_MDIS: assert property ((!running || !full) |=> multiphase_disable_out_o.oe)
      else $error("multiphase disable not pulled low");
   AST_ZC: assert property ((mode == MPM_MD_RPM_DCM && s.zc) |=> zero_cross_out_o.oe)
      else $error("zero cross not pulled low");

   AST_HIZ_P2: assert property ((running && !st_r.en_mask[1]) [*2] |-> !phase2_pulse_out_o.oe)
      else $error("disabled phase 2 driven");
   AST_OE_OFF: assert property (!running |=> !phase1_pulse_out_o.oe && !phase2_pulse_out_o.oe
      && !phase3_pulse_out_o.oe)
      else $error("phase pin driven while off");
   AST_SINK_IDLE: assert property ((st_r.fsm != MPM_ST_PROBE) |-> probe_sink_o == 2'h0)
      else $error("probe sink active outside probing");
   AST_PROBE_MASK: assert property ((st_r.fsm == MPM_ST_PROBE && st_r.enable && st_r.tick
      && st_r.pcnt == `MPM_PROBE_TICKS - 2'h1) |=> st_r.en_mask[1] == !$past(s.p2hi))
      else $error("phase 2 strap not captured");
   AST_HEAVY: assert property ((running && s.power_state_in && !s.dslp) |-> mode == MPM_MD_PWM
      && act_mask == st_r.en_mask)
      else $error("heavy load not running all phases");
   AST_TRANS_FULL: assert property ((running && trans) |-> mode == MPM_MD_PWM)
      else $error("transient window not forcing pwm");
   AST_RPM_OWN: assert property (seq_rpm_level |=> phase1_pulse_out_o.out == $past(st_r.rpm_p1))
      else $error("ripple mode phase 1 not following its latch");
   AST_RPM_HOLD: assert property ((running && !full && st_r.rpm_p1 && !s.ramp) |=> st_r.rpm_p1)
      else $error("ripple pulse ended before ramp reached");
   AST_PWM_ON_TICK: assert property ((|(pg_pulse & ~$past(pg_pulse))) |-> $past(st_r.tick))
      else $error("pwm pulse started off the master clock");
   // a divider write landing on a reload cycle would trip this; software sets it before enable
   AST_TICK_RELOAD: assert property (st_r.tick |-> st_r.div_cnt == st_r.div)
      else $error("master clock tick off its divider");
   AST_WIN_DSLP: assert property ((running && s.dslp != st_r.dslp_q) |=> st_r.mask_cnt == MASK_LOAD)
      else $error("deeper sleep change did not open window");
   AST_WIN_COUNT: assert property (seq_window_hold |=> st_r.mask_cnt == $past(st_r.mask_cnt) - 16'h0001)
      else $error("transient window not counting down");
   AST_MDIS_OFF: assert property ((running && full) |=> !multiphase_disable_out_o.oe)
      else $error("multiphase disable pulled low in full phase");
   AST_ZC_OFF: assert property ((mode != MPM_MD_RPM_DCM) |=> !zero_cross_out_o.oe)
      else $error("zero cross pulled low outside dcm");
endmodule : mpm_top
`default_nettype wire

// >>> pkg/mpm_consts.svh
// constants for the multiphase mode control block
// assumes a 50 MHz system clock and a word-wide wishbone bus
`ifndef MPM_CONSTS_SVH
`define MPM_CONSTS_SVH
// ************************************************************
// register map (byte addresses)
// ************************************************************
`define MPM_ADR_CTRL 4'h0
`define MPM_ADR_STAT 4'h4
`define MPM_ADR_DIV 4'h8
// ************************************************************
// field positions and reset values
// ************************************************************
`define MPM_CTRL_EN 0
`define MPM_DIV_RST 16'h0019
`define MPM_DIV_RST_W 32'h00000019
// ************************************************************
// timing
// ************************************************************
`define MPM_PROBE_TICKS 2'h3
`define MPM_CLK_MHZ 50
`define MPM_MASK_US 100
`define MPM_MASK_CYC (`MPM_MASK_US * `MPM_CLK_MHZ)
`define MPM_SYNC_W 18
`endif

// >>> pkg/mpm_pkg.sv
// types shared by the multiphase mode control block
// assumes mpm_consts.svh is on the include path
package mpm_pkg;
   typedef enum logic [1:0] {
      MPM_ST_OFF = 2'b00,
      MPM_ST_PROBE = 2'b01,
      MPM_ST_RUN = 2'b10
   } mpm_fsm_t;

   typedef enum logic [1:0] {
      MPM_MD_OFF = 2'b00,
      MPM_MD_PWM = 2'b01,
      MPM_MD_RPM_CCM = 2'b10,
      MPM_MD_RPM_DCM = 2'b11
   } mpm_mode_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } mpm_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } mpm_wb_rsp_t;

   // one two-signal pin: drive level, drive enable
   typedef struct packed {
      logic out;
      logic oe;
   } mpm_pin_t;

   typedef struct packed {
      logic power_state_in;
      logic dslp;
      logic ilim;
      logic trip;
      logic ramp;
      logic zc;
      logic p2hi;
      logic p3hi;
      logic [2:0] pwm_end;
      logic [6:0] voltage_id_code;
   } mpm_sys_t;

   typedef struct packed {
      mpm_sys_t q1;
      mpm_sys_t q2;
   } mpm_sync_st_t;

   typedef struct packed {
      logic [1:0] slot;
      logic [2:0] pulse;
   } mpm_pg_st_t;

   typedef struct packed {
      mpm_fsm_t fsm;
      logic [1:0] pcnt;
      logic [15:0] div_cnt;
      logic tick;
      logic [1:0] nph;
      logic [2:0] en_mask;
      logic [15:0] mask_cnt;
      logic [6:0] vid_q;
      logic dslp_q;
      logic rpm_p1;
      logic enable;
      logic [15:0] div;
      logic ack;
      logic [31:0] rdat;
      logic [2:0] out;
      logic [2:0] oe;
      logic sink;
      logic md_oe;
      logic zc_oe;
   } mpm_core_st_t;
endpackage : mpm_pkg

// >>> design/mpm_sync.sv
// two-flop synchroniser for every pin input of the block
// assumes inputs are asynchronous to clock_i
`timescale 1ns/1ps
`default_nettype none
module mpm_sync (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire mpm_pkg::mpm_sys_t d_i,
   output mpm_pkg::mpm_sys_t q_o
);
   import mpm_pkg::*;
   mpm_sync_st_t st_r;
   mpm_sync_st_t st_nxt;

   // first stage feeds only the second stage
   always_comb begin
      st_nxt.q1 = d_i;
      st_nxt.q2 = st_r.q1;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q_o = st_r.q2;
endmodule : mpm_sync
`default_nettype wire

// >>> design/mpm_phase_gen.sv
// interleaved pwm slot generator for up to three phases
// assumes tick_i is one cycle per master clock period
`timescale 1ns/1ps
`default_nettype none
module mpm_phase_gen (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic [1:0] nph_i,
   input wire logic [2:0] en_i,
   input wire logic [2:0] end_i,
   output logic [2:0] pulse_o
);
   import mpm_pkg::*;
   mpm_pg_st_t st_r;
   mpm_pg_st_t st_nxt;
   logic [2:0] pulse_nxt;

   // each phase owns its own flop, so pulses may overlap
   genvar k;
   generate
      for (k = 0; k < 3; k++) begin : g_ph
         // start wins over end so a near-full duty never drops a period
         assign pulse_nxt[k] = !en_i[k] ? 1'b0 :
            (tick_i && st_r.slot == 2'(k)) ? 1'b1 :
            end_i[k] ? 1'b0 : st_r.pulse[k];
      end
   endgenerate

   always_comb begin
      st_nxt = st_r;
      st_nxt.pulse = pulse_nxt;
      if (tick_i) begin
         // per phase rate is master divided by phases in use
         st_nxt.slot = (st_r.slot + 2'h1 >= nph_i) ? 2'h0 : st_r.slot + 2'h1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pulse_o = st_r.pulse;
endmodule : mpm_phase_gen
`default_nettype wire

// >>> tb/mpm_drv_model.sv
// gate driver stand-in and phase strap wiring seen by the mode block
// assumes pin levels and enables come straight from mpm_top outputs
`timescale 1ns/1ps
`default_nettype none
module mpm_drv_model (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [1:0] tie_i,
   input wire logic [1:0] sink_i,
   input wire logic [2:0] out_i,
   input wire logic [2:0] oe_i,
   output logic [2:0] pwm_end_o,
   output logic p2_high_o,
   output logic p3_high_o
);
   logic [1:0] on_r [3];
   // ************************************************************
   // strap and probe comparators
   // ************************************************************
   // a tied pin reads high; a free pin under the sink reads low
   assign p2_high_o = tie_i[0] | (~sink_i[0] & oe_i[1] & out_i[1]);
   assign p3_high_o = tie_i[1] | (~sink_i[1] & oe_i[2] & out_i[2]);
   // ************************************************************
   // pulse end comparators
   // ************************************************************
   // end comparator trips after two cycles high; with pipeline delay a pulse lasts seven cycles, ending one cycle before the next single-phase slot
   always_ff @(posedge clock_i) begin
      for (int k = 0; k < 3; k++) begin
         on_r[k] <= (rst_i | ~out_i[k]) ? 2'h0 : ((on_r[k] == 2'h2) ? 2'h2 : on_r[k] + 2'h1);
         pwm_end_o[k] <= out_i[k] & (on_r[k] == 2'h2);
      end
   end
endmodule : mpm_drv_model
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the multiphase mode control block
// assumes the driver model stands on the phase pins, divider set to 7
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import mpm_pkg::*;
   logic clock_i, rst_i, power_state_in, dslp, ilim, trip, ramp, zcd, p2h, p3h;
   logic [6:0] voltage_id_code;
   logic [2:0] pend, pout, poe;
   logic [1:0] sink, tie;
   logic [31:0] q;
   mpm_wb_req_t req;
   mpm_wb_rsp_t rsp;
   mpm_pin_t ph1, ph2, ph3, mdis, zco;
   int failures, n_tests, cyc_n, n;
   assign pout = {ph3.out, ph2.out, ph1.out};
   assign poe = {ph3.oe, ph2.oe, ph1.oe};
   // short mask window keeps the transient scenarios brief
   mpm_top #(.MASK_CYCLES(20)) uut (.clock_i(clock_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
      .power_state_in_i(power_state_in), .deeper_sleep_in_i(dslp), .current_limit_i(ilim), .voltage_id_code_i(voltage_id_code),
      .ripple_trip_i(trip), .ramp_reach_i(ramp), .zero_cross_det_i(zcd), .pwm_end_i(pend),
      .phase2_probe_high_i(p2h), .phase3_probe_high_i(p3h), .phase1_pulse_out_o(ph1),
      .phase2_pulse_out_o(ph2), .phase3_pulse_out_o(ph3), .probe_sink_o(sink),
      .multiphase_disable_out_o(mdis), .zero_cross_out_o(zco));
   mpm_drv_model drv (.clock_i(clock_i), .rst_i(rst_i), .tie_i(tie), .sink_i(sink), .out_i(pout),
      .oe_i(poe), .pwm_end_o(pend), .p2_high_o(p2h), .p3_high_o(p3h));
   // ************************************************************
   // shared tasks
   // ************************************************************
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task conclude;
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   // request held until ack is sampled; one idle cycle follows; a hang is left to the watchdog
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
      do begin
         @(posedge clock_i);
      end while (rsp.ack !== 1'b1);
      q = rsp.dat;
      req <= '0;
      @(posedge clock_i);
   endtask : wb
   task rise(input int k, input int lim);
      logic p;
      n = 0;
      p = 1'b1;
      while (n < lim && !(p === 1'b0 && pout[k] === 1'b1)) begin
         p = pout[k];
         @(posedge clock_i);
         n++;
      end
   endtask : rise
   task stat_mode(input string name, input mpm_mode_t m);
      wb(1'b0, 4'h4, 32'h0);
      chk(name, 32'(q[3:2]), 32'(m));
   endtask : stat_mode
   task do_reset;
      rst_i <= 1'b1;
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
   endtask : do_reset
   // ************************************************************
   // scenarios
   // ************************************************************
   task t_reset;
      do_reset();
      chk("oe_rst", 32'(poe), 32'h0);
      chk("md_rst", 32'(mdis.oe), 32'h1);
      chk("sink_rst", 32'(sink), 32'h0);
      chk("od_levels", 32'({mdis.out, zco.out}), 32'h0);
      wb(1'b0, 4'h8, 32'h0);
      chk("div_rst", q, 32'h00000019);
      wb(1'b0, 4'hC, 32'h0);
      chk("unmapped", q, 32'h0);
   endtask : t_reset
   task t_strap(input logic [1:0] t, input int nph, input logic [2:0] mask);
      tie <= t;
      do_reset();
      wb(1'b1, 4'h8, 32'h00000007);
      wb(1'b1, 4'h0, 32'h00000001);
      n = 0;
      while (sink !== 2'h3 && n < 10) begin
         @(posedge clock_i);
         n++;
      end
      chk("sink_on", 32'(sink), 32'h3);
      n = 0;
      while (sink === 2'h3 && n < 40) begin
         @(posedge clock_i);
         n++;
      end
      chk("probe_len", 32'(n >= 16 && n <= 25), 32'h1);
      chk("sink_off", 32'(sink), 32'h0);
      repeat (4) @(posedge clock_i);
      chk("oe_mask", 32'(poe), 32'(mask));
      wb(1'b0, 4'h4, 32'h0);
      chk("en_mask", 32'(q[8:6]), 32'(mask));
      chk("phases", 32'(q[1:0]), 32'(nph));
      chk("mode_pwm", 32'(q[3:2]), 32'(MPM_MD_PWM));
      if (nph > 1) chk("md_multi", 32'(mdis.oe), 32'h0);
      rise(0, 100);
      rise(0, 100);
      chk("period", 32'(n), 32'(8 * nph));
      if (nph > 1) begin
         rise(1, 100);
         chk("interleave", 32'(n), 32'h8);
      end
   endtask : t_strap
   task t_modes;
      power_state_in <= 1'b0;
      repeat (6) @(posedge clock_i);
      stat_mode("mode_rpm", MPM_MD_RPM_CCM);
      chk("md_single", 32'(mdis.oe), 32'h1);
      chk("ph2_idle", 32'(pout[1]), 32'h0);
      rise(0, 40);
      chk("no_clock", 32'(n), 32'd40);
      trip <= 1'b1;
      rise(0, 10);
      trip <= 1'b0;
      chk("trip_rise", 32'(n), 32'd5);
      ramp <= 1'b1;
      n = 0;
      while (pout[0] !== 1'b0 && n < 10) begin
         @(posedge clock_i);
         n++;
      end
      ramp <= 1'b0;
      chk("ramp_fall", 32'(n), 32'd5);
      ilim <= 1'b1;
      repeat (6) @(posedge clock_i);
      stat_mode("mode_ilim", MPM_MD_PWM);
      ilim <= 1'b0;
      dslp <= 1'b1;
      repeat (5) @(posedge clock_i);
      wb(1'b0, 4'h4, 32'h0);
      chk("trans_dslp", 32'(q[4]), 32'h1);
      chk("mode_trans", 32'(q[3:2]), 32'(MPM_MD_PWM));
      repeat (40) @(posedge clock_i);
      stat_mode("mode_dcm", MPM_MD_RPM_DCM);
      chk("zc_idle", 32'(zco.oe), 32'h0);
      zcd <= 1'b1;
      repeat (5) @(posedge clock_i);
      chk("zero_cross", 32'(zco.oe), 32'h1);
      zcd <= 1'b0;
      dslp <= 1'b0;
      repeat (40) @(posedge clock_i);
      voltage_id_code <= voltage_id_code + 7'h01;
      n = cyc_n;
      repeat (5) @(posedge clock_i);
      stat_mode("mode_vid", MPM_MD_PWM);
      while (q[4] !== 1'b0 && cyc_n - n < 60) wb(1'b0, 4'h4, 32'h0);
      n = cyc_n - n;
      chk("window_len", 32'(n >= 20 && n <= 27), 32'h1);
      stat_mode("mode_after", MPM_MD_RPM_CCM);
      power_state_in <= 1'b1;
      repeat (6) @(posedge clock_i);
      stat_mode("mode_heavy", MPM_MD_PWM);
   endtask : t_modes
   // ************************************************************
   // clock, watchdog and main sequence
   // ************************************************************
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   always @(posedge clock_i) cyc_n <= cyc_n + 1;
   initial begin
      repeat (30000) @(posedge clock_i);
      failures++;
      conclude();
   end
   initial begin
      {rst_i, power_state_in, dslp, ilim, trip, ramp, zcd} = 7'h40;
      power_state_in = 1'b1;
      voltage_id_code = 7'h20;
      tie = 2'h0;
      req = '0;
      failures = 0;
      n_tests = 0;
      cyc_n = 0;
      t_reset();
      t_strap(2'h3, 1, 3'h1);
      t_strap(2'h2, 2, 3'h3);
      t_strap(2'h0, 3, 3'h7);
      t_modes();
      conclude();
   end
endmodule : tb_top
`default_nettype wire
